// File: hw/eit_pkg.sv
/*
 * Constants shared by the eight-bit interval timer: register addresses,
 * reset values, field positions and count clock division codes.
 * Assumes an 8-bit special function register port with a 16-bit address.
 */
package eit_pkg;

   // ---------------------------------------------------------------
   // register addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] EIT_ADDR_CLOCK_SELECT = 16'hFF73;
   localparam logic [15:0] EIT_ADDR_MODE_CONTROL = 16'hFF76;
   localparam logic [15:0] EIT_ADDR_COUNT_VALUE  = 16'hFF6C;
   localparam logic [15:0] EIT_ADDR_MATCH_VALUE  = 16'hFF6D;

   // ---------------------------------------------------------------
   // reset values and fields
   // ---------------------------------------------------------------
   localparam logic [7:0]  EIT_CLOCK_SELECT_RST = 8'h00;
   localparam logic [7:0]  EIT_MODE_CONTROL_RST = 8'h04;
   localparam logic [7:0]  EIT_COUNT_RST        = 8'h00;
   localparam logic [7:0]  EIT_MATCH_RST        = 8'h00;
   localparam logic [7:0]  EIT_READ_IDLE        = 8'h00;
   localparam logic [7:0]  EIT_COUNT_ONE        = 8'h01;
   localparam int          EIT_RUN_BIT          = 7;
   localparam int          EIT_SEL_MSB          = 2;

   // ---------------------------------------------------------------
   // prescaler: main oscillator is the system clock
   // ---------------------------------------------------------------
   localparam int          EIT_PRE_W            = 11;
   localparam logic [10:0] EIT_PRE_ONE          = 11'h001;
   localparam logic [10:0] EIT_PRE_ZERO         = 11'h000;
   localparam logic [10:0] EIT_MASK_DIV8        = 11'h007;
   localparam logic [10:0] EIT_MASK_DIV16       = 11'h00F;
   localparam logic [10:0] EIT_MASK_DIV32       = 11'h01F;
   localparam logic [10:0] EIT_MASK_DIV128      = 11'h07F;
   localparam logic [10:0] EIT_MASK_DIV512      = 11'h1FF;
   localparam logic [10:0] EIT_MASK_DIV2048     = 11'h7FF;

   typedef enum logic [2:0] {
      EIT_SEL_BAD0    = 3'h0,
      EIT_SEL_BAD1    = 3'h1,
      EIT_SEL_DIV8    = 3'h2,
      EIT_SEL_DIV16   = 3'h3,
      EIT_SEL_DIV32   = 3'h4,
      EIT_SEL_DIV128  = 3'h5,
      EIT_SEL_DIV512  = 3'h6,
      EIT_SEL_DIV2048 = 3'h7
   } eit_sel_t;

endpackage : eit_pkg

// File: hw/eit_prescaler.sv
/*
 * Free-running divider of the main oscillator and count clock selector.
 * Emits a one-cycle tick at each rising edge of the selected count clock.
 * Assumes clk_sys is the main oscillator; rst_b synchronous, active low.
 */
`timescale 1ns/100ps
module eit_prescaler
   import eit_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic [2:0] clock_select,
   output logic            count_tick
);

   logic [EIT_PRE_W-1:0] pre_reg;
   logic [EIT_PRE_W-1:0] pre_next;
   logic                 tick_reg;
   logic                 tick_next;
   logic [EIT_PRE_W-1:0] mask;

   // ---------------------------------------------------------------
   // divider and selection
   // ---------------------------------------------------------------
   always_comb begin
      pre_next = pre_reg + EIT_PRE_ONE;
      unique case (eit_sel_t'(clock_select))
         EIT_SEL_DIV8    : mask = EIT_MASK_DIV8;
         EIT_SEL_DIV16   : mask = EIT_MASK_DIV16;
         EIT_SEL_DIV32   : mask = EIT_MASK_DIV32;
         EIT_SEL_DIV128  : mask = EIT_MASK_DIV128;
         EIT_SEL_DIV512  : mask = EIT_MASK_DIV512;
         EIT_SEL_DIV2048 : mask = EIT_MASK_DIV2048;
         EIT_SEL_BAD0,
         EIT_SEL_BAD1    : mask = EIT_PRE_ZERO;
      endcase
      // prohibited codes give no count clock at all
      tick_next = (mask != EIT_PRE_ZERO) && ((pre_reg & mask) == mask);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pre_reg  <= EIT_PRE_ZERO;
         tick_reg <= 1'b0;
      end else begin
         pre_reg  <= pre_next;
         tick_reg <= tick_next;
      end
   end

   assign count_tick = tick_reg;

endmodule : eit_prescaler

// File: hw/eit_timer.sv
/*
 * Eight-bit interval timer: count clock select, mode control with run bit,
 * read-only interval counter and match value with periodic match request.
 * Assumes a single-cycle special function register port synchronous to
 * clk_sys (10 MHz main oscillator), byte writes and single-bit writes.
 */
`timescale 1ns/100ps
module eit_timer
   import eit_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [15:0] sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_bit_wr,
   input  wire logic [2:0]  sfr_bit_sel,
   input  wire logic        sfr_bit_val,
   input  wire logic        sfr_rd,
   output logic [7:0]       sfr_rdata,
   output logic             match_irq
);

   logic [7:0] clock_select_reg;
   logic [7:0] clock_select_next;
   logic [7:0] mode_control_reg;
   logic [7:0] mode_control_next;
   logic [7:0] match_value_reg;
   logic [7:0] match_value_next;
   logic [7:0] interval_counter_reg;
   logic [7:0] interval_counter_next;
   logic       pend_tick_reg;
   logic       pend_tick_next;
   logic       match_irq_reg;
   logic       match_irq_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       count_tick;
   logic       tick_eff;
   logic       count_run_bit;
   logic       rd_counter;
   logic       wr_clock_select;
   logic       wr_mode_control;
   logic       wr_match_value;
   logic       bit_wr_mode;
   logic [7:0] mode_bit_sel;
   logic       match_hit;

   // ---------------------------------------------------------------
   // count clock source
   // ---------------------------------------------------------------
   eit_prescaler u_prescaler (
      .clk_sys      (clk_sys),
      .rst_b        (rst_b),
      .clock_select (clock_select_reg[EIT_SEL_MSB:0]),
      .count_tick   (count_tick)
   );

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   assign wr_clock_select = sfr_wr && sfr_addr == EIT_ADDR_CLOCK_SELECT;
   assign wr_mode_control = sfr_wr && sfr_addr == EIT_ADDR_MODE_CONTROL;
   assign wr_match_value  = sfr_wr && sfr_addr == EIT_ADDR_MATCH_VALUE;
   // byte write wins over a bit write in the same cycle
   assign bit_wr_mode     = sfr_bit_wr && !sfr_wr && sfr_addr == EIT_ADDR_MODE_CONTROL;
   assign rd_counter      = sfr_rd && sfr_addr == EIT_ADDR_COUNT_VALUE;

   // one-hot target of a single-bit write to mode control
   for (genvar i = 0; i < $bits(mode_control_reg); i++) begin : g_mode_bit
      assign mode_bit_sel[i] = bit_wr_mode && (sfr_bit_sel == 3'(i));
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_comb begin
      clock_select_next = clock_select_reg;
      mode_control_next = mode_control_reg;
      match_value_next  = match_value_reg;
      if (wr_clock_select) begin
         clock_select_next = sfr_wdata;
      end
      if (wr_mode_control) begin
         mode_control_next = sfr_wdata;
      end else begin
         mode_control_next = (mode_control_reg & ~mode_bit_sel) | ({8{sfr_bit_val}} & mode_bit_sel);
      end
      if (wr_match_value) begin
         match_value_next = sfr_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         clock_select_reg <= EIT_CLOCK_SELECT_RST;
         mode_control_reg <= EIT_MODE_CONTROL_RST;
         match_value_reg  <= EIT_MATCH_RST;
      end else begin
         clock_select_reg <= clock_select_next;
         mode_control_reg <= mode_control_next;
         match_value_reg  <= match_value_next;
      end
   end

   // run bit acts at its own write edge, so a stop zeroes at once
   assign count_run_bit = mode_control_next[EIT_RUN_BIT];
   assign match_hit     = interval_counter_reg == match_value_reg;

   // ---------------------------------------------------------------
   // counter, read hold-off and match request
   // ---------------------------------------------------------------
   always_comb begin
      // a tick during a counter read is deferred, not lost
      tick_eff              = (count_tick || pend_tick_reg) && !rd_counter;
      // a fresh tick meeting a deferred one stays pending
      pend_tick_next        = rd_counter ? (count_tick || pend_tick_reg) : (count_tick && pend_tick_reg);
      interval_counter_next = interval_counter_reg;
      match_irq_next        = 1'b0;
      if (!count_run_bit) begin
         interval_counter_next = EIT_COUNT_RST;
         pend_tick_next        = 1'b0;
      end else if (tick_eff) begin
         // prescaler free-runs, so the first tick after start may be early
         if (match_hit) begin
            interval_counter_next = EIT_COUNT_RST;
            match_irq_next        = 1'b1;
         end else begin
            // wraps through ff to zero when match lies below
            interval_counter_next = interval_counter_reg + EIT_COUNT_ONE;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         interval_counter_reg <= EIT_COUNT_RST;
         pend_tick_reg        <= 1'b0;
         match_irq_reg        <= 1'b0;
      end else begin
         interval_counter_reg <= interval_counter_next;
         pend_tick_reg        <= pend_tick_next;
         match_irq_reg        <= match_irq_next;
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_comb begin
      rdata_next = EIT_READ_IDLE;
      if (sfr_rd) begin
         unique case (sfr_addr)
            EIT_ADDR_CLOCK_SELECT : rdata_next = clock_select_reg;
            EIT_ADDR_MODE_CONTROL : rdata_next = mode_control_reg;
            EIT_ADDR_COUNT_VALUE  : rdata_next = interval_counter_reg;
            EIT_ADDR_MATCH_VALUE  : rdata_next = match_value_reg;
            default               : rdata_next = EIT_READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rdata_reg <= EIT_READ_IDLE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign sfr_rdata = rdata_reg;
   assign match_irq = match_irq_reg;

endmodule : eit_timer

// File: bench/eit_checker.sv
/* port assertions for the interval timer
   assumes binding to eit_timer, single clk_sys domain */
`timescale 1ns/100ps
module eit_checker
   import eit_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic [15:0] sfr_addr,
   input wire logic        sfr_wr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic        sfr_bit_wr,
   input wire logic [2:0]  sfr_bit_sel,
   input wire logic        sfr_bit_val,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        match_irq
);
   // ---------------------------------------------------------------
   // request gap counter and properties
   // ---------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic [11:0] gap_reg;
   logic [11:0] gap_next;
   always_comb gap_next = match_irq ? 12'h000 : ((gap_reg == 12'hFFF) ? gap_reg : gap_reg + 12'h001);
   always_ff @(posedge clk_sys) gap_reg <= rst_b ? gap_next : 12'hFFF;
   sequence s_wr(a); sfr_wr && sfr_addr == a; endsequence
   sequence s_rd(a); sfr_rd && sfr_addr == a && !sfr_wr && !sfr_bit_wr; endsequence
   sequence s_stop; s_wr(EIT_ADDR_MODE_CONTROL) ##0 !sfr_wdata[EIT_RUN_BIT]; endsequence
   AST_IRQ_PULSE: assert property (match_irq |=> !match_irq) else $error("irq wider than one cycle");
   AST_RD_IDLE: assert property (!sfr_rd |=> sfr_rdata == EIT_READ_IDLE) else $error("rdata not idle");
   AST_MODE_BACK: assert property (s_wr(EIT_ADDR_MODE_CONTROL) ##1 s_rd(EIT_ADDR_MODE_CONTROL)
      |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("mode readback wrong");
   AST_SEL_BACK: assert property (s_wr(EIT_ADDR_CLOCK_SELECT) ##1 s_rd(EIT_ADDR_CLOCK_SELECT)
      |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("select readback wrong");
   AST_MATCH_BACK: assert property (s_wr(EIT_ADDR_MATCH_VALUE) ##1 s_rd(EIT_ADDR_MATCH_VALUE)
      |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("match readback wrong");
   AST_SPACING: assert property (match_irq |-> gap_reg >= 12'h007) else $error("irq too close");
   AST_STOP_QUIET: assert property (s_stop ##1 (!sfr_wr && !sfr_bit_wr)[*4] |-> !match_irq)
      else $error("irq while stopped");
   AST_STOP_ZERO: assert property (s_stop ##1 s_rd(EIT_ADDR_COUNT_VALUE)
      |=> sfr_rdata == EIT_COUNT_RST) else $error("counter not zero after stop");
endmodule : eit_checker
bind eit_timer eit_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
   .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .match_irq(match_irq));

// File: bench/test_eit_timer.sv
/* self-checking bench for the interval timer
   assumes eit_pkg and eit_timer; inputs change at falling edges */
`timescale 1ns/100ps
module test_eit_timer;
   import eit_pkg::*;
   logic        clk_sys, rst_b, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, match_irq;
   logic [15:0] sfr_addr;
   logic [7:0]  sfr_wdata, sfr_rdata, v0, v1;
   logic [2:0]  sfr_bit_sel;
   int          bad_count = 0, n_checks = 0, n;
   int          dv[8] = '{0, 0, 8, 16, 32, 128, 512, 2048};
   eit_timer u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .match_irq(match_irq));
   // ---------------------------------------------------------------
   // port tasks, all entered at a falling edge
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one bus cycle: every strobe set once, read data taken after the edge
   task automatic xfer(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d, input logic [2:0] s,
                       output logic [7:0] v);
      {sfr_wr, sfr_bit_wr, sfr_rd} = k;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_bit_sel = s;
      sfr_bit_val = d[0];
      @(negedge clk_sys) v = sfr_rdata;
   endtask : xfer
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] u;
      xfer(3'h4, a, d, 3'h0, u);
   endtask : wr
   task automatic bwr(input logic [15:0] a, input logic [2:0] s, input logic b);
      logic [7:0] u;
      xfer(3'h2, a, {7'h00, b}, s, u);
   endtask : bwr
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      xfer(3'h1, a, 8'h00, 3'h0, v);
   endtask : rd
   task automatic idle(input int c);
      logic [7:0] u;
      repeat (c) xfer(3'h0, 16'h0000, 8'h00, 3'h0, u);
   endtask : idle
   task automatic wait_irq(input int lim, output int c);
      c = 0;
      do begin
         idle(1);
         c++;
      end while (match_irq !== 1'b1 && c < lim);
   endtask : wait_irq
   task automatic start(input logic [7:0] s, input logic [7:0] m);
      wr(EIT_ADDR_MODE_CONTROL, 8'h04);
      wr(EIT_ADDR_CLOCK_SELECT, s);
      wr(EIT_ADDR_MATCH_VALUE, m);
      wr(EIT_ADDR_MODE_CONTROL, 8'h84);
   endtask : start
   task automatic t_reset();
      logic [15:0] a[5] = '{16'hFF73, 16'hFF76, 16'hFF6C, 16'hFF6D, 16'hFF70};
      logic [7:0] e[5] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 5; i++) begin
         rd(a[i], v0);
         chk("reset value", e[i], v0);
      end
   endtask : t_reset
   task automatic t_regs();
      wr(EIT_ADDR_CLOCK_SELECT, 8'h05);
      rd(EIT_ADDR_CLOCK_SELECT, v0);
      chk("select", 8'h05, v0);
      bwr(EIT_ADDR_CLOCK_SELECT, 3'h1, 1'b1);
      rd(EIT_ADDR_CLOCK_SELECT, v0);
      chk("select bit write", 8'h05, v0);
      wr(EIT_ADDR_MATCH_VALUE, 8'hFF);
      rd(EIT_ADDR_MATCH_VALUE, v0);
      chk("match", 8'hFF, v0);
      wr(EIT_ADDR_COUNT_VALUE, 8'h33);
      rd(EIT_ADDR_COUNT_VALUE, v0);
      chk("count ro", 8'h00, v0);
      bwr(EIT_ADDR_MODE_CONTROL, 3'h7, 1'b1);
      rd(EIT_ADDR_MODE_CONTROL, v0);
      chk("mode run", 8'h84, v0);
      wr(EIT_ADDR_MODE_CONTROL, 8'h04);
      rd(EIT_ADDR_COUNT_VALUE, v0);
      chk("count stop", 8'h00, v0);
      wr(EIT_ADDR_MODE_CONTROL, 8'h84);
      rd(EIT_ADDR_MODE_CONTROL, v0);
      chk("mode byte", 8'h84, v0);
   endtask : t_regs
   task automatic t_period();
      for (int s = 2; s < 8; s++) begin
         start(s[7:0], (s == 2) ? 8'h00 : 8'h01);
         wait_irq(3 * dv[s] + 9, n);
         chk("first match", 1, n <= ((s == 2) ? 2 : 3) * dv[s] + 8);
         wait_irq(3 * dv[s], n);
         chk("interval", ((s == 2) ? 1 : 2) * dv[s], n);
      end
      for (int s = 0; s < 2; s++) begin
         start(s[7:0], 8'h00);
         wait_irq(100, n);
         chk("no ticks", 100, n);
      end
   endtask : t_period
   task automatic t_read();
      // slower count clock for reading; a match gives the tick phase
      start(8'h03, 8'h00);
      wait_irq(60, n);
      wr(EIT_ADDR_MATCH_VALUE, 8'hFF);
      idle(13);
      rd(EIT_ADDR_COUNT_VALUE, v0);
      repeat (3) rd(EIT_ADDR_COUNT_VALUE, v1);
      chk("read hold", v0, v1);
      idle(1);
      rd(EIT_ADDR_COUNT_VALUE, v1);
      chk("read resume", v0 + 8'h01, v1);
      idle(15);
      rd(EIT_ADDR_COUNT_VALUE, v1);
      chk("count step", v0 + 8'h02, v1);
   endtask : t_read
   task automatic t_lower();
      start(8'h02, 8'h20);
      wait_irq(400, n);
      idle(128);
      wr(EIT_ADDR_MATCH_VALUE, 8'h05);
      wait_irq(2500, n);
      chk("overflow detour", 1, n > 1800 && n < 2100);
      start(8'h02, 8'h05);
      wait_irq(60, n);
      chk("restart first", 1, n <= 56);
      wait_irq(60, n);
      chk("restart interval", 48, n);
      wr(EIT_ADDR_MODE_CONTROL, 8'h04);
      idle(6);
   endtask : t_lower
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      {rst_b, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_bit_sel} = 8'h00;
      sfr_addr = 16'h0000;
      sfr_wdata = 8'h00;
      repeat (8) @(negedge clk_sys);
      rst_b = 1'b1;
      t_reset();
      t_regs();
      t_period();
      t_read();
      t_lower();
      give_verdict();
   end
   initial begin
      #4000000;
      bad_count++;
      give_verdict();
   end
endmodule : test_eit_timer
